// ==== rtl/rsc_pkg.sv ====
// package: register map, field positions, reset values and states of the standby control block
package rsc_pkg;
   // register byte offsets
   localparam logic [7:0] RSC_OFF_CFG = 8'h00; // command register selector
   localparam logic [7:0] RSC_OFF_CMD = 8'h04; // command word
   localparam logic [7:0] RSC_OFF_REV = 8'h08; // reverse transfer word (standby side)
   localparam logic [7:0] RSC_OFF_STAT = 8'h0c; // status word
   localparam logic [7:0] RSC_OFF_PADDR = 8'h10; // base port addresses
   localparam logic [7:0] RSC_OFF_EVT = 8'h14; // events and mismatch input
   localparam logic [7:0] RSC_OFF_SIZE = 8'h18; // transfer option bit
   // command word bit positions, numbered from 1 at the msb as printed
   localparam int RSC_CMD_OVR = 16 - 16; // keyswitch override
   localparam int RSC_CMD_RUN_A = 16 - 15; // controller A run state
   localparam int RSC_CMD_RUN_B = 16 - 14; // controller B run state
   localparam int RSC_CMD_MISM_RUN = 16 - 13; // mismatch option: stay online
   localparam int RSC_CMD_SWAP1 = 16 - 8; // port 1 swap at switchover
   localparam int RSC_CMD_SWAP2 = 16 - 7;
   localparam int RSC_CMD_SWAP3 = 16 - 6;
   // status word bit positions
   localparam int RSC_ST_MPROT_OFF = 16 - 11; // standby memory protect off
   localparam int RSC_ST_BATT_FAIL = 16 - 12; // standby battery failed
   localparam int RSC_ST_PRIMARY = 16 - 15; // this unit is primary
   localparam int RSC_ST_ONLINE = 16 - 16; // this unit is online
   // reset values
   localparam logic [15:0] RSC_CFG_RST = 16'h0000;
   localparam logic [15:0] RSC_CMD_RST = 16'h0700;
   localparam logic [31:0] RSC_PADDR_RST = 32'h0003_0201;
   // register selection constants
   localparam logic [19:0] RSC_HOLD_BASE = 20'h6_1a80; // holding register 400000
   localparam logic [15:0] RSC_FIXED_MAX = 16'h2328; // 9000
   localparam logic [7:0] RSC_ADDR_MIN = 8'h01;
   localparam logic [7:0] RSC_ADDR_MAX = 8'h77; // 119
   localparam logic [7:0] RSC_ADDR_OFS = 8'h80; // 128
   localparam logic [7:0] RSC_ADDR_TOP = 8'hf7; // 247
   localparam logic [1:0] RSC_RESP_OKAY = 2'b00;
   localparam logic [1:0] RSC_RESP_SLVERR = 2'b10;
   // controller role states
   typedef enum logic [1:0] {
      RSC_OFFLINE = 2'b00,
      RSC_STANDBY = 2'b01,
      RSC_PRIMARY = 2'b10
   } rsc_role_t;
endpackage

// ==== rtl/rsc_sync.sv ====
// three flip-flop synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
module rsc_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic din,
   output logic dout
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   // shift chain; first stage only feeds the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   // a change counts once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dout <= 1'b0;
      end else if (s2_q == s3_q) begin
         dout <= s3_q;
      end
   end
endmodule // rsc_sync

// ==== rtl/rsc_portmap.sv ====
// port address assignment for one serial port, swapped on switchover
`timescale 1ns/1ns
module rsc_portmap
   import rsc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] base_addr,
   input wire logic is_primary,
   input wire logic swap_en,
   input wire logic switchover,
   output logic [7:0] addr
);
   logic offset_q; // this unit holds the offset address
   logic hold_q; // a switchover has fixed the offset
   logic [7:0] base;
   // clamp the base into the legal primary range
   assign base = (base_addr < RSC_ADDR_MIN) ? RSC_ADDR_MIN :
                 (base_addr > RSC_ADDR_MAX) ? RSC_ADDR_MAX : base_addr;
   // offset follows the role until a switchover; after that only a switchover moves it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         offset_q <= 1'b0;
         hold_q <= 1'b0;
      end else if (switchover) begin
         offset_q <= swap_en && is_primary;
         hold_q <= 1'b1;
      end else if (!hold_q) begin
         offset_q <= !is_primary; // standby side holds the offset
      end
   end
   // output address, at most 247
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr <= RSC_ADDR_MIN;
      end else begin
         addr <= offset_q ? base + RSC_ADDR_OFS : base;
      end
   end
endmodule // rsc_portmap

// ==== rtl/rsc_ctrl.sv ====
// redundant controller standby control: command decode, role, switchover, reverse transfer
// How it works
// - selector resets to zero; nonzero n picks holding register 400000 plus n
// - override defaults off; bit 16 set makes command bits control online state
// - override on: startup state from own run bit; program updates refused
// - slide switch input decides whether this unit is A or B
// - override turning on samples bits 14 and 15 at once
// - both run bits zero on enable forces switchover; old primary goes offline
// - bit 14 is B run state; writing 1 while B offline runs it
// - default: mismatch takes standby offline; switchover blocked while offline
// - mismatch option run keeps standby online despite mismatch
// - switchover under mismatch with run option makes standby primary
// - primary port addresses 1 to 119; standby adds 128, max 247
// - offset follows the standby role at switchover by default
// - standby reverse-transfer word is copied back to the primary
// - standby status reports memory protect off bit 11, battery fail bit 12
// - only the primary runs I/O logic; standby runs first portion only
// - configuration loads at startup and accepts runtime command writes
// - nontransfer block: two reverse registers, then the status word; code has one reverse word (0x08) before the status word (0x0c)
// - port 1 swap bit change acts only at the next switchover
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module rsc_ctrl
   import rsc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic slide_sw_b,
   input wire logic keyswitch_run,
   input wire logic peer_online,
   input wire logic peer_primary,
   input wire logic [15:0] peer_rev_word,
   input wire logic peer_fail,
   output logic unit_online,
   output logic unit_primary,
   output logic io_logic_en,
   output logic diag_logic_en,
   output logic update_refused,
   output logic switchover_req,
   output logic [15:0] fwd_cmd_word,
   output logic [15:0] rev_word_out,
   output logic [19:0] cmd_reg_ref,
   output logic [7:0] port1_addr,
   output logic [7:0] port2_addr,
   output logic [7:0] port3_addr
);
   ////////////////////////////////////////////////////////////////////////////
   logic is_b;
   logic key_run;
   logic [15:0] cfg_q;
   logic [15:0] cmd_q;
   logic [15:0] rev_q;
   logic [15:0] rev_in_q;
   logic [31:0] paddr_q;
   logic mism_q;
   logic mprot_off_q;
   logic batt_fail_q;
   logic fixed_q;
   logic ovr_prev_q;
   logic startup_q;
   rsc_role_t role_q;
   logic aw_q;
   logic w_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_fire;
   logic wr_hit;
   logic rd_hit;
   logic [31:0] rd_val;
   logic own_run;
   logic peer_run;
   logic ovr_rise;
   logic go_switch;
   logic mism_off;
   logic [15:0] status_word;
   logic [15:0] wmask;

   ////////////////////////////////////////////////////////////////////////////
   // pin inputs through three-stage synchronisers
   rsc_sync u_sync_ab (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(slide_sw_b),
      .dout(is_b)
   );
   rsc_sync u_sync_key (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(keyswitch_run),
      .dout(key_run)
   );

   ////////////////////////////////////////////////////////////////////////////
   // axi write: take address and data in either order, answer once both held
   assign wr_fire = aw_q && w_q && !s_axi_bvalid;
   assign wr_hit = (awaddr_q[7:2] <= RSC_OFF_SIZE[7:2]) && (awaddr_q != RSC_OFF_STAT);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RSC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RSC_RESP_OKAY : RSC_RESP_SLVERR;
            aw_q <= 1'b0;
            w_q <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // byte lane mask for the low half word
   assign wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers: reset load, then runtime writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q <= RSC_CFG_RST;
         cmd_q <= RSC_CMD_RST;
         paddr_q <= RSC_PADDR_RST;
         rev_q <= 16'h0000;
         mprot_off_q <= 1'b0;
         batt_fail_q <= 1'b0;
         mism_q <= 1'b0;
         fixed_q <= 1'b0;
      end else if (wr_fire) begin
         unique case (awaddr_q)
            RSC_OFF_CFG: cfg_q <= (cfg_q & ~wmask) | (wdata_q[15:0] & wmask);
            RSC_OFF_CMD: cmd_q <= (cmd_q & ~wmask) | (wdata_q[15:0] & wmask);
            RSC_OFF_REV: rev_q <= (rev_q & ~wmask) | (wdata_q[15:0] & wmask);
            RSC_OFF_PADDR: begin
               if (wstrb_q[0]) paddr_q[7:0] <= wdata_q[7:0];
               if (wstrb_q[1]) paddr_q[15:8] <= wdata_q[15:8];
               if (wstrb_q[2]) paddr_q[23:16] <= wdata_q[23:16];
            end
            RSC_OFF_EVT: if (wstrb_q[0]) begin
               mism_q <= wdata_q[0];
               mprot_off_q <= wdata_q[1];
               batt_fail_q <= wdata_q[2];
            end
            RSC_OFF_SIZE: if (wstrb_q[0]) fixed_q <= wdata_q[0];
            default: ;
         endcase
      end
   end

   // command register reference as a holding register number
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_reg_ref <= 20'h0_0000;
      end else begin
         cmd_reg_ref <= (cfg_q == 16'h0000) ? 20'h0_0000 : RSC_HOLD_BASE + {4'h0, cfg_q};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // run intent: bit 15 for A, bit 14 for B; keyswitch when override is off
   assign own_run = is_b ? cmd_q[RSC_CMD_RUN_B] : cmd_q[RSC_CMD_RUN_A];
   assign peer_run = is_b ? cmd_q[RSC_CMD_RUN_A] : cmd_q[RSC_CMD_RUN_B];
   assign ovr_rise = cmd_q[RSC_CMD_OVR] && !ovr_prev_q;
   assign mism_off = mism_q && !cmd_q[RSC_CMD_MISM_RUN];
   // switchover: on override enable with both bits zero, or peer primary lost
   assign go_switch = (role_q == RSC_PRIMARY && ovr_rise && !own_run && !peer_run) ||
                      (role_q == RSC_STANDBY && !mism_off && peer_fail);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ovr_prev_q <= 1'b0;
         startup_q <= 1'b1;
      end else begin
         ovr_prev_q <= cmd_q[RSC_CMD_OVR];
         startup_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // role state machine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         role_q <= RSC_OFFLINE;
      end else begin
         unique case (role_q)
            RSC_OFFLINE: begin
               if (startup_q) begin
                  role_q <= RSC_OFFLINE;
               end else if (!mism_off && (cmd_q[RSC_CMD_OVR] ? own_run : key_run)) begin
                  role_q <= (peer_primary && peer_online) ? RSC_STANDBY : RSC_PRIMARY;
               end
            end
            RSC_STANDBY: begin
               if (mism_off || (cmd_q[RSC_CMD_OVR] ? !own_run : !key_run)) begin
                  role_q <= RSC_OFFLINE;
               end else if (go_switch || !peer_online) begin
                  role_q <= RSC_PRIMARY;
               end
            end
            RSC_PRIMARY: begin
               if (go_switch) begin
                  role_q <= RSC_OFFLINE;
               end else if (cmd_q[RSC_CMD_OVR] ? !own_run : !key_run) begin
                  role_q <= RSC_OFFLINE;
               end
            end
            default: role_q <= RSC_OFFLINE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // role outputs and switchover pulse to the peer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         unit_online <= 1'b0;
         unit_primary <= 1'b0;
         io_logic_en <= 1'b0;
         diag_logic_en <= 1'b0;
         update_refused <= 1'b0;
         switchover_req <= 1'b0;
      end else begin
         unit_online <= role_q != RSC_OFFLINE;
         unit_primary <= role_q == RSC_PRIMARY;
         io_logic_en <= role_q == RSC_PRIMARY;
         diag_logic_en <= role_q != RSC_OFFLINE;
         update_refused <= cmd_q[RSC_CMD_OVR];
         switchover_req <= go_switch;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // forward and reverse transfer of words
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fwd_cmd_word <= RSC_CMD_RST;
         rev_word_out <= 16'h0000;
         rev_in_q <= 16'h0000;
      end else begin
         fwd_cmd_word <= cmd_q; // command goes forward, status block does not
         rev_word_out <= (role_q == RSC_STANDBY) ? status_word : 16'h0000;
         if (role_q == RSC_PRIMARY) begin
            rev_in_q <= peer_rev_word;
         end
      end
   end

   // status word of this unit
   always_comb begin
      status_word = rev_q;
      status_word[RSC_ST_MPROT_OFF] = mprot_off_q;
      status_word[RSC_ST_BATT_FAIL] = batt_fail_q;
      status_word[RSC_ST_PRIMARY] = role_q == RSC_PRIMARY;
      status_word[RSC_ST_ONLINE] = role_q != RSC_OFFLINE;
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-port address swapping
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_port
         logic [7:0] pa;
         rsc_portmap u_pm (
            .aclk(aclk),
            .aresetn(aresetn),
            .base_addr(paddr_q[gi*8 +: 8]),
            .is_primary(role_q == RSC_PRIMARY),
            .swap_en(cmd_q[RSC_CMD_SWAP1 + gi]),
            .switchover(go_switch || (role_q == RSC_STANDBY && !peer_online)),
            .addr(pa)
         );
         if (gi == 0) begin : g_p1
            assign port1_addr = pa;
         end else if (gi == 1) begin : g_p2
            assign port2_addr = pa;
         end else begin : g_p3
            assign port3_addr = pa;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // axi read: one cycle after the address is taken
   assign rd_hit = s_axi_araddr[7:2] <= RSC_OFF_SIZE[7:2];
   always_comb begin
      rd_val = 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
         RSC_OFF_CFG: rd_val = {16'h0000, cfg_q};
         RSC_OFF_CMD: rd_val = {16'h0000, cmd_q};
         RSC_OFF_REV: rd_val = {16'h0000, rev_in_q};
         RSC_OFF_STAT: rd_val = {16'h0000, status_word};
         RSC_OFF_PADDR: rd_val = {8'h00, paddr_q[23:0]};
         RSC_OFF_EVT: rd_val = {29'h0000_0000, batt_fail_q, mprot_off_q, mism_q};
         RSC_OFF_SIZE: rd_val = {31'h0000_0000, fixed_q};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RSC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_hit ? RSC_RESP_OKAY : RSC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule // rsc_ctrl

// ==== tb/rsc_monitor.sv ====
// concurrent checks on the standby control block ports
`timescale 1ns/1ns
module rsc_monitor
   import rsc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic unit_primary,
   input wire logic io_logic_en,
   input wire logic switchover_req,
   input wire logic update_refused,
   input wire logic [15:0] fwd_cmd_word,
   input wire logic [15:0] rev_word_out,
   input wire logic [7:0] port1_addr
);
   // one clock domain, reset masks every check
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////////
   // register bus answers and busy windows
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid)
      else $error("write response did not follow the write");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data did not follow the read address");
   a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channels ready while a response is pending");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address ready while read data is pending");
   // role and override dependent outputs
   a_io_primary: assert property (io_logic_en |-> unit_primary)
      else $error("io logic enabled on a non primary unit");
   a_port_range: assert property (port1_addr inside {[RSC_ADDR_MIN:RSC_ADDR_MAX],
      [RSC_ADDR_MIN + RSC_ADDR_OFS:RSC_ADDR_TOP]})
      else $error("port address outside the legal ranges");
   a_switch_pulse: assert property (switchover_req |=> !switchover_req)
      else $error("switchover request longer than one cycle");
   a_update_refuse: assert property ((fwd_cmd_word[RSC_CMD_OVR] == $past(fwd_cmd_word[RSC_CMD_OVR]))
      |-> update_refused == fwd_cmd_word[RSC_CMD_OVR])
      else $error("update refusal does not follow the override bit");
   a_primary_rev_zero: assert property (unit_primary && $past(unit_primary) && $past(unit_primary, 2)
      |-> rev_word_out == 16'h0000)
      else $error("primary unit still drives a reverse word");
endmodule // rsc_monitor
////////////////////////////////////////////////////////////////////////////////
bind rsc_ctrl rsc_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .unit_primary, .io_logic_en, .switchover_req,
   .update_refused, .fwd_cmd_word, .rev_word_out, .port1_addr);

// ==== tb/rsc_peer_model.sv ====
// behavioural model of the peer controller across the redundancy link
`timescale 1ns/1ns
module rsc_peer_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic up,
   input wire logic fault,
   input wire logic [15:0] word,
   input wire logic unit_primary,
   output logic peer_online,
   output logic peer_primary,
   output logic [15:0] peer_rev_word,
   output logic peer_fail
);
   // peer is primary while healthy and the unit has not taken over; status word only while standby
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         peer_online <= 1'b0;
         peer_primary <= 1'b0;
         peer_fail <= 1'b0;
         peer_rev_word <= 16'h0000;
      end else begin
         peer_online <= up;
         peer_primary <= up && !fault && !unit_primary;
         peer_fail <= fault;
         peer_rev_word <= peer_primary ? 16'h0000 : word;
      end
   end
endmodule // rsc_peer_model

// ==== tb/tb_top.sv ====
// self-checking bench for the standby control block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin miscompares++; \
   $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module tb_top;
   import rsc_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic keyswitch_run = 1'b0, peer_fault = 1'b0, slide_b = 1'b0;
   logic peer_online, peer_primary, peer_fail, unit_online, unit_primary, io_logic_en, diag_logic_en;
   logic update_refused, switchover_req;
   logic [15:0] peer_rev_word, fwd_cmd_word, rev_word_out;
   logic [19:0] cmd_reg_ref;
   logic [7:0] port1_addr, port2_addr, port3_addr;
   int miscompares = 0, cmp_count = 0, sw_cnt = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // clock and count of switchover pulses
   initial begin
      forever #2 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (aresetn && switchover_req === 1'b1) sw_cnt <= sw_cnt + 1;
   end
   // block and peer
   rsc_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .slide_sw_b(slide_b),
      .keyswitch_run(keyswitch_run), .peer_online(peer_online), .peer_primary(peer_primary),
      .peer_rev_word(peer_rev_word), .peer_fail(peer_fail), .unit_online(unit_online),
      .unit_primary(unit_primary), .io_logic_en(io_logic_en), .diag_logic_en(diag_logic_en),
      .update_refused(update_refused), .switchover_req(switchover_req), .fwd_cmd_word(fwd_cmd_word),
      .rev_word_out(rev_word_out), .cmd_reg_ref(cmd_reg_ref), .port1_addr(port1_addr),
      .port2_addr(port2_addr), .port3_addr(port3_addr));
   rsc_peer_model peer (.aclk(aclk), .aresetn(aresetn), .up(1'b1), .fault(peer_fault), .word(16'h0030),
      .unit_primary(unit_primary), .peer_online(peer_online), .peer_primary(peer_primary),
      .peer_rev_word(peer_rev_word), .peer_fail(peer_fail));
   ////////////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic tally_and_finish;
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic give_up(input string what);
      miscompares++;
      $display("[FAIL] %s exp done got timeout", what);
      tally_and_finish();
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask
   // bus write: address and data offered together, each released when taken
   task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rex);
      int n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 200);
      if (bvalid !== 1'b1) give_up("write");
      `CHK("bresp", rex, bresp)
      bready <= 1'b0;
   endtask
   // bus read with data and response compare
   task automatic rchk(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] rex);
      int n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 200);
      if (rvalid !== 1'b1) give_up("read");
      `CHK("rdata", ex, rdata)
      `CHK("rresp", rex, rresp)
      rready <= 1'b0;
   endtask
   // bounded wait: 0 online, 1 primary, 2 port 1 at base address
   task automatic wt(input int k, input logic v);
      logic s;
      for (int n = 0; n < 300; n++) begin
         cyc(1);
         s = k == 0 ? unit_online : (k == 1 ? unit_primary : port1_addr == 8'h01);
         if (s === v) return;
      end
      give_up("wait");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [15:0] cmd;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(RSC_OFF_CFG, 32'h0000_0000, RSC_RESP_OKAY);
      rchk(RSC_OFF_CMD, {16'h0000, RSC_CMD_RST}, RSC_RESP_OKAY);
      rchk(RSC_OFF_PADDR, RSC_PADDR_RST, RSC_RESP_OKAY);
      `CHK("cmd_reg_ref", 20'h0_0000, cmd_reg_ref)
      rchk(8'h1c, 32'h0000_0000, RSC_RESP_SLVERR);
      wchk(RSC_OFF_STAT, 32'h0000_ffff, RSC_RESP_SLVERR);
      wchk(RSC_OFF_CFG, 32'h0000_000e, RSC_RESP_OKAY);
      cyc(2);
      `CHK("cmd_reg_ref", RSC_HOLD_BASE + 20'h0_000e, cmd_reg_ref)
      cyc(20);
      `CHK("online", 1'b0, unit_online)
      @(posedge aclk);
      keyswitch_run <= 1'b1;
      wt(0, 1'b1);
      `CHK("primary", 1'b0, unit_primary)
      `CHK("io_en", 1'b0, io_logic_en)
      `CHK("diag_en", 1'b1, diag_logic_en)
      `CHK("port1", 8'h81, port1_addr)
      `CHK("port2", 8'h82, port2_addr)
      `CHK("port3", 8'h83, port3_addr)
      wchk(RSC_OFF_EVT, 32'h0000_0006, RSC_RESP_OKAY);
      cyc(3);
      `CHK("mprot", 1'b1, rev_word_out[RSC_ST_MPROT_OFF])
      `CHK("batt", 1'b1, rev_word_out[RSC_ST_BATT_FAIL])
      // mismatch under the default option: standby offline, takeover blocked
      wchk(RSC_OFF_EVT, 32'h0000_0007, RSC_RESP_OKAY);
      wt(0, 1'b0);
      @(posedge aclk);
      peer_fault <= 1'b1;
      cyc(30);
      `CHK("primary", 1'b0, unit_primary)
      `CHK("switches", 0, sw_cnt)
      @(posedge aclk);
      peer_fault <= 1'b0;
      cmd = RSC_CMD_RST | (16'h0001 << RSC_CMD_MISM_RUN);
      wchk(RSC_OFF_CMD, {16'h0000, cmd}, RSC_RESP_OKAY);
      wt(0, 1'b1);
      // takeover with the mismatch still present
      @(posedge aclk);
      peer_fault <= 1'b1;
      wt(1, 1'b1);
      wt(2, 1'b1);
      `CHK("switches", 1, sw_cnt)
      `CHK("io_en", 1'b1, io_logic_en)
      rchk(RSC_OFF_REV, 32'h0000_0030, RSC_RESP_OKAY);
      cmd = cmd & ~(16'h0001 << RSC_CMD_SWAP1);
      wchk(RSC_OFF_CMD, {16'h0000, cmd}, RSC_RESP_OKAY);
      cyc(10);
      `CHK("port1", 8'h01, port1_addr)
      // override on with both run bits clear, then own run bit set
      @(posedge aclk);
      keyswitch_run <= 1'b0;
      cmd = cmd | (16'h0001 << RSC_CMD_OVR);
      wchk(RSC_OFF_CMD, {16'h0000, cmd}, RSC_RESP_OKAY);
      wt(0, 1'b0);
      `CHK("switches", 2, sw_cnt)
      `CHK("refused", 1'b1, update_refused)
      cmd = cmd | (16'h0001 << RSC_CMD_RUN_A);
      wchk(RSC_OFF_CMD, {16'h0000, cmd}, RSC_RESP_OKAY);
      wt(0, 1'b1);
      // unit becomes controller B, whose run bit is still clear
      @(posedge aclk);
      slide_b <= 1'b1;
      wt(0, 1'b0);
      cmd = cmd | (16'h0001 << RSC_CMD_RUN_B);
      wchk(RSC_OFF_CMD, {16'h0000, cmd}, RSC_RESP_OKAY);
      wt(0, 1'b1);
      tally_and_finish();
   end
endmodule // tb_top
